// ---- rtl/epp_regs.vh ----
// Purpose: Register offsets, field positions and codes for the eight pin port
// Assumes: Byte wide registers, byte addresses as printed
// Notes:   Definitions only
`ifndef EPP_REGS_VH
`define EPP_REGS_VH

// Primary window
`define EPP_DRIVE_ENABLE        5'h00
`define EPP_DRIVE_ENABLE_SET    5'h01
`define EPP_DRIVE_ENABLE_CLR    5'h02
`define EPP_DRIVE_ENABLE_TGL    5'h03
`define EPP_OUTPUT_LEVEL        5'h04
`define EPP_OUTPUT_LEVEL_SET    5'h05
`define EPP_OUTPUT_LEVEL_CLR    5'h06
`define EPP_OUTPUT_LEVEL_TGL    5'h07
`define EPP_INPUT_VALUE         5'h08
`define EPP_PIN_EVENT_FLAGS     5'h09
`define EPP_PER_PIN_CONFIG_BASE 5'h10
`define EPP_RESERVED_SLOT       5'h0A

// Fast alias window
`define EPP_ALIAS_DRIVE_ENABLE  5'h00
`define EPP_ALIAS_OUTPUT_LEVEL  5'h01
`define EPP_ALIAS_INPUT_VALUE   5'h02
`define EPP_ALIAS_EVENT_FLAGS   5'h03

// Per pin config fields
`define EPP_CFG_SWAP_BIT        7
`define EPP_CFG_BIAS_BIT        3
`define EPP_CFG_SENSE_MSB       2
`define EPP_CFG_SENSE_LSB       0
`define EPP_CFG_WRITE_MASK      8'h8F

// Sense select codes
`define EPP_SENSE_OFF_BUF_ON    3'h0
`define EPP_SENSE_ANY_EDGE      3'h1
`define EPP_SENSE_RISING        3'h2
`define EPP_SENSE_FALLING       3'h3
`define EPP_SENSE_BUF_OFF       3'h4
`define EPP_SENSE_LOW_LEVEL     3'h5

// Reset values
`define EPP_RESET_BYTE          8'h00
`define EPP_SYNC_RESET          8'h00

// Enabled edges after reset before the synchroniser output may be trusted
`define EPP_WARM_EDGES          2'h2

`endif

// ---- rtl/epp_sync.v ----
// Purpose: Two flip-flop synchroniser for the eight pin inputs
// Assumes: Pins are asynchronous to core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`include "epp_regs.vh"

module epp_sync (
  // Clock and control
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clk_en,
  // Data
  input  wire [7:0] async_in,
  output reg  [7:0] sync_out
);

  reg [7:0] stage_one;

  always @(posedge core_clk) begin
    if (rst) begin
      stage_one <= `EPP_SYNC_RESET;
      sync_out  <= `EPP_SYNC_RESET;
    end else if (clk_en) begin
      // Frozen with the clock enable, as sampling halts with the clock
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ---- rtl/epp_port.v ----
// Purpose: Eight pin general purpose I/O port with strobe aliases and pin events
// Assumes: Single core_clk domain, synchronous active high reset, byte register port
// Notes:   Registers reachable through the primary window, four of them also through the fast alias window
//
// What this block does
// - Output level bit one drives pin high
// - Output level only drives pins set as outputs
// - Set strobe sets output bits written one
// - Clear strobe clears output bits written one
// - Toggle strobe inverts output bits written one
// - Output strobes read back the output level
// - Input value shows pin while buffer enabled
// - Writing input value toggles output level bits
// - Event flag sets on matching sense condition
// - Writing one to event flag clears it
// - Polarity swap inverts input and output paths
// - Pull-up enable bit turns on pin bias
// - Sense select decodes edges, level, buffer off
// - Eight config registers at 0x10 plus n
// - Alias window maps four registers, same effects
// - Direction bit one makes pin an output
// - Direction strobes set, clear, toggle; read direction
// - Logic runs on core clock, halts with it
`timescale 1ns/10ps
`include "epp_regs.vh"

module epp_port (
  // Clock, reset and enable
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clk_en,
  // Register port
  input  wire       alias_sel,
  input  wire [4:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Pins
  input  wire [7:0] pin_in,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe,
  output reg  [7:0] weak_high_bias_enable,
  // Status
  output reg  [7:0] pin_event_flags
);

  // Per pin sense decode: is this sample an event for the selected mode
  function sense_hit;
    input [2:0] sense;
    input       cur;
    input       prev;
    begin
      case (sense)
        `EPP_SENSE_ANY_EDGE:  sense_hit = cur ^ prev;
        `EPP_SENSE_RISING:    sense_hit = cur & ~prev;
        `EPP_SENSE_FALLING:   sense_hit = ~cur & prev;
        `EPP_SENSE_LOW_LEVEL: sense_hit = ~cur;
        default:              sense_hit = 1'b0;
      endcase
    end
  endfunction

  // Map an access to a primary offset; alias offsets fold onto primaries
  function [4:0] primary_offset;
    input       is_alias;
    input [4:0] addr;
    begin
      if (!is_alias) begin
        primary_offset = addr;
      end else begin
        case (addr)
          `EPP_ALIAS_DRIVE_ENABLE: primary_offset = `EPP_DRIVE_ENABLE;
          `EPP_ALIAS_OUTPUT_LEVEL: primary_offset = `EPP_OUTPUT_LEVEL;
          `EPP_ALIAS_INPUT_VALUE:  primary_offset = `EPP_INPUT_VALUE;
          `EPP_ALIAS_EVENT_FLAGS:  primary_offset = `EPP_PIN_EVENT_FLAGS;
          // Unmapped alias offset lands on a reserved primary slot
          default:                 primary_offset = `EPP_RESERVED_SLOT;
        endcase
      end
    end
  endfunction

  // Plain write, set, clear or toggle of one byte register
  function [7:0] strobe_apply;
    input [1:0] kind;
    input [7:0] cur;
    input [7:0] data;
    begin
      case (kind)
        2'h0:    strobe_apply = data;
        2'h1:    strobe_apply = cur | data;
        2'h2:    strobe_apply = cur & ~data;
        default: strobe_apply = cur ^ data;
      endcase
    end
  endfunction

  // Field pickers for one per pin config byte
  function cfg_swap;
    input [7:0] cfg;
    begin
      cfg_swap = cfg[`EPP_CFG_SWAP_BIT];
    end
  endfunction

  function cfg_bias;
    input [7:0] cfg;
    begin
      cfg_bias = cfg[`EPP_CFG_BIAS_BIT];
    end
  endfunction

  function [2:0] cfg_sense;
    input [7:0] cfg;
    begin
      cfg_sense = cfg[`EPP_CFG_SENSE_MSB:`EPP_CFG_SENSE_LSB];
    end
  endfunction

  reg  [7:0] drive_enable;
  reg  [7:0] output_level;
  reg  [7:0] input_value;
  reg  [7:0] per_pin_config [0:7];
  reg  [7:0] level_prev;
  reg        prev_valid;
  reg  [1:0] sync_fill;

  wire [7:0] pin_sync;
  wire [4:0] eff_addr;
  wire       cfg_hit;
  wire [2:0] cfg_idx;

  reg  [7:0] next_drive_enable;
  reg  [7:0] next_output_level;
  reg  [7:0] next_flags;
  reg  [7:0] next_rdata;
  reg  [7:0] swap_mask;
  reg  [7:0] bias_mask;
  reg  [7:0] buf_on;
  reg  [7:0] level_now;
  reg  [7:0] event_hit;
  reg  [7:0] next_swap_mask;
  reg  [7:0] next_bias_mask;
  integer    i;
  integer    j;
  integer    k;

  epp_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  assign eff_addr = primary_offset(alias_sel, reg_addr);
  assign cfg_hit  = !alias_sel && ({reg_addr[4:3], 3'b000} == `EPP_PER_PIN_CONFIG_BASE);
  assign cfg_idx  = reg_addr[2:0];

  // Per pin views of the config registers
  always @* begin
    swap_mask = 8'h00;
    bias_mask = 8'h00;
    buf_on    = 8'h00;
    level_now = 8'h00;
    event_hit = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      swap_mask[i] = cfg_swap(per_pin_config[i]);
      bias_mask[i] = cfg_bias(per_pin_config[i]);
      buf_on[i]    = cfg_sense(per_pin_config[i]) != `EPP_SENSE_BUF_OFF;
      level_now[i] = pin_sync[i] ^ swap_mask[i];
      // Edges need a valid previous sample; a disabled buffer senses nothing
      event_hit[i] = buf_on[i] && (prev_valid || cfg_sense(per_pin_config[i]) == `EPP_SENSE_LOW_LEVEL) &&
                     sense_hit(cfg_sense(per_pin_config[i]), level_now[i], level_prev[i]);
    end
  end

  // Config bits as they stand after this edge, so pins follow a config write at once
  always @* begin
    next_swap_mask = swap_mask;
    next_bias_mask = bias_mask;
    if (reg_wr && cfg_hit) begin
      next_swap_mask[cfg_idx] = cfg_swap(reg_wdata);
      next_bias_mask[cfg_idx] = cfg_bias(reg_wdata);
    end
  end

  // Write side effects on direction and output level
  always @* begin
    next_drive_enable = drive_enable;
    next_output_level = output_level;
    if (reg_wr) begin
      case (eff_addr)
        `EPP_DRIVE_ENABLE:     next_drive_enable = strobe_apply(2'h0, drive_enable, reg_wdata);
        `EPP_DRIVE_ENABLE_SET: next_drive_enable = strobe_apply(2'h1, drive_enable, reg_wdata);
        `EPP_DRIVE_ENABLE_CLR: next_drive_enable = strobe_apply(2'h2, drive_enable, reg_wdata);
        `EPP_DRIVE_ENABLE_TGL: next_drive_enable = strobe_apply(2'h3, drive_enable, reg_wdata);
        `EPP_OUTPUT_LEVEL:     next_output_level = strobe_apply(2'h0, output_level, reg_wdata);
        `EPP_OUTPUT_LEVEL_SET: next_output_level = strobe_apply(2'h1, output_level, reg_wdata);
        `EPP_OUTPUT_LEVEL_CLR: next_output_level = strobe_apply(2'h2, output_level, reg_wdata);
        `EPP_OUTPUT_LEVEL_TGL: next_output_level = strobe_apply(2'h3, output_level, reg_wdata);
        `EPP_INPUT_VALUE:      next_output_level = strobe_apply(2'h3, output_level, reg_wdata);
        default: begin
          next_drive_enable = drive_enable;
          next_output_level = output_level;
        end
      endcase
    end
  end

  // Flags: a new event wins over a clearing write in the same cycle
  always @* begin
    next_flags = pin_event_flags;
    if (reg_wr && eff_addr == `EPP_PIN_EVENT_FLAGS) begin
      next_flags = pin_event_flags & ~reg_wdata;
    end
    next_flags = next_flags | event_hit;
  end

  // Read mux; reserved and unmapped locations read zero
  always @* begin
    next_rdata = 8'h00;
    if (cfg_hit) begin
      next_rdata = per_pin_config[cfg_idx];
    end else begin
      case (eff_addr)
        `EPP_DRIVE_ENABLE,
        `EPP_DRIVE_ENABLE_SET,
        `EPP_DRIVE_ENABLE_CLR,
        `EPP_DRIVE_ENABLE_TGL: next_rdata = drive_enable;
        `EPP_OUTPUT_LEVEL,
        `EPP_OUTPUT_LEVEL_SET,
        `EPP_OUTPUT_LEVEL_CLR,
        `EPP_OUTPUT_LEVEL_TGL: next_rdata = output_level;
        `EPP_INPUT_VALUE:      next_rdata = input_value;
        `EPP_PIN_EVENT_FLAGS:  next_rdata = pin_event_flags;
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // Direction, output level and flags
  always @(posedge core_clk) begin
    if (rst) begin
      drive_enable    <= `EPP_RESET_BYTE;
      output_level    <= `EPP_RESET_BYTE;
      pin_event_flags <= `EPP_RESET_BYTE;
    end else if (clk_en) begin
      drive_enable    <= next_drive_enable;
      output_level    <= next_output_level;
      pin_event_flags <= next_flags;
    end
  end

  // Per pin config store
  always @(posedge core_clk) begin
    if (rst) begin
      for (j = 0; j < 8; j = j + 1) begin
        per_pin_config[j] <= `EPP_RESET_BYTE;
      end
    end else if (clk_en && reg_wr && cfg_hit) begin
      per_pin_config[cfg_idx] <= reg_wdata & `EPP_CFG_WRITE_MASK;
    end
  end

  // The synchroniser restarts from zero, so a high pin would look like a
  // rising edge; edges count only once the previous sample is a real one
  always @(posedge core_clk) begin
    if (rst) begin
      sync_fill  <= 2'h0;
      prev_valid <= 1'b0;
    end else if (clk_en) begin
      if (sync_fill != 2'h3) begin
        sync_fill <= sync_fill + 2'h1;
      end
      prev_valid <= (sync_fill >= `EPP_WARM_EDGES);
    end
  end

  // Input value and previous conditioned sample
  always @(posedge core_clk) begin
    if (rst) begin
      input_value <= `EPP_RESET_BYTE;
      level_prev  <= `EPP_RESET_BYTE;
    end else if (clk_en) begin
      for (k = 0; k < 8; k = k + 1) begin
        // A disabled buffer holds its last sample rather than tracking the pin
        if (buf_on[k]) begin
          input_value[k] <= level_now[k];
          level_prev[k]  <= level_now[k];
        end
      end
    end
  end

  // Read data holds until the next read
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= `EPP_RESET_BYTE;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Pins change on the same edge as the registers behind them
  always @(posedge core_clk) begin
    if (rst) begin
      pin_out               <= `EPP_RESET_BYTE;
      pin_oe                <= `EPP_RESET_BYTE;
      weak_high_bias_enable <= `EPP_RESET_BYTE;
    end else if (clk_en) begin
      pin_oe                <= next_drive_enable;
      pin_out               <= next_output_level ^ next_swap_mask;
      weak_high_bias_enable <= next_bias_mask;
    end
  end

endmodule

// ---- tb/epp_checker.sv ----
// Purpose: Assertions on the eight pin port boundary
// Assumes: One clock, rst synchronous active high
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module epp_checker (
  // Clock and register port
  input logic       core_clk,
  input logic       rst,
  input logic       clk_en,
  input logic       alias_sel,
  input logic [4:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  // Pins and status
  input logic [7:0] pin_in,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] weak_high_bias_enable,
  input logic [7:0] pin_event_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [2:0] cfg_pin;
  logic       cfg_bias;
  wire wr  = clk_en && reg_wr;
  wire pri = wr && !alias_sel;
  wire tgl = pri && (reg_addr == 5'h07 || reg_addr == 5'h08) || wr && alias_sel && reg_addr == 5'h02;
  wire clr = pri && reg_addr == 5'h09 || wr && alias_sel && reg_addr == 5'h03;
  wire dst = pri && reg_addr != 5'h00 && reg_addr < 5'h04;
  wire cfw = pri && reg_addr[4:3] == 2'b10;
  wire unm = clk_en && reg_rd && (alias_sel ? reg_addr > 5'h03 : reg_addr > 5'h09 && reg_addr[4:3] != 2'b10);
  // Remember which pin a config write aimed at
  always @(posedge core_clk) begin
    cfg_pin  <= reg_addr[2:0];
    cfg_bias <= reg_wdata[3];
  end
  property p_reset; disable iff (1'b0) rst |=> {pin_out, pin_oe, weak_high_bias_enable, pin_event_flags} == 32'h0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_freeze; !clk_en |=> $stable({pin_out, pin_oe, pin_event_flags, reg_rdata}); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
  property p_dir; wr && reg_addr == 5'h00 |=> pin_oe == $past(reg_wdata); endproperty
  a_dir: assert property (p_dir) else $error("direction write not on pins");
  property p_dir_strobe; dst |=> pin_oe == ($past(reg_addr) == 5'h01 ? $past(pin_oe) | $past(reg_wdata) :
    $past(reg_addr) == 5'h02 ? $past(pin_oe) & ~$past(reg_wdata) : $past(pin_oe) ^ $past(reg_wdata)); endproperty
  a_dir_strobe: assert property (p_dir_strobe) else $error("direction strobe wrong");
  property p_toggle; tgl |=> pin_out == ($past(pin_out) ^ $past(reg_wdata)); endproperty
  a_toggle: assert property (p_toggle) else $error("output toggle wrong");
  property p_flag; !clr |=> ($past(pin_event_flags) & ~pin_event_flags) == 8'h00; endproperty
  a_flag: assert property (p_flag) else $error("flag dropped without clear");
  property p_bias; cfw |=> weak_high_bias_enable[cfg_pin] == cfg_bias; endproperty
  a_bias: assert property (p_bias) else $error("pull-up not following config");
  property p_unmapped; unm |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_clear: cover property (clr && pin_event_flags != 8'h00);
  c_toggle: cover property (tgl);
  c_freeze: cover property (!clk_en && reg_wr);
endmodule

// ---- tb/epp_pin_model.sv ----
// Purpose: Outside circuitry on the eight port pins
// Assumes: Bench may drive any pin; port drive wins over it
// Notes:   A released pin with no pull-up wanders every cycle
`timescale 1ns/10ps
module epp_pin_model (
  // Port side
  input  logic       core_clk,
  input  logic [7:0] pin_out,
  input  logic [7:0] pin_oe,
  input  logic [7:0] weak_high_bias_enable,
  // Bench side
  input  logic [7:0] ext_en,
  input  logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] wander = 8'h55;
  always @(posedge core_clk) begin
    wander <= ~wander;
  end
  // Port drive wins, then outside drive, then pull-up; else no stable level
  assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en & (weak_high_bias_enable | wander));
endmodule

// ---- tb/test_eight_pin_io_port.sv ----
// Purpose: Self-checking bench for the eight pin port
// Assumes: Pin model resolves every pin level
// Notes:   Expected register state kept in bench variables
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_eight_pin_io_port;
  logic       core_clk  = 1'b0;
  logic       rst       = 1'b1;
  logic       clk_en    = 1'b1;
  logic       alias_sel = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       s;
  logic [4:0] reg_addr  = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] ext_en    = 8'hFF;
  logic [7:0] ext_val   = 8'h00;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, weak_high_bias_enable, pin_event_flags, dir_e, out_e, r, d;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         a;
  always #25 core_clk = ~core_clk;
  epp_port DUT (.core_clk, .rst, .clk_en, .alias_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
                .pin_in, .pin_out, .pin_oe, .weak_high_bias_enable, .pin_event_flags);
  epp_pin_model PINS (.core_clk, .pin_out, .pin_oe, .weak_high_bias_enable, .ext_en, .ext_val, .pin_in);
  function automatic logic [7:0] upd(input logic [1:0] k, input logic [7:0] o, input logic [7:0] w);
    return k == 2'd0 ? w : k == 2'd1 ? o | w : k == 2'd2 ? o & ~w : o ^ w;
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic sel, input logic [4:0] ad, input logic [7:0] dt);
    @(posedge core_clk);
    alias_sel <= sel;
    reg_addr  <= ad;
    reg_wdata <= dt;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic sel, input logic [4:0] ad);
    @(posedge core_clk);
    alias_sel <= sel;
    reg_addr  <= ad;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Guards against a hang anywhere below
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(78314));
    dir_e = 8'h00;
    out_e = 8'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      rd(1'b0, 5'(i < 10 ? i : i + 6));
      `CHK("reset value", 8'h00, d)
    end
    for (int i = 0; i < 40; i++) begin
      a = $urandom_range(8, 0);
      r = $urandom;
      s = ($urandom_range(1, 0) == 1) && (a % 4 == 0);
      wr(s, 5'(s ? a / 4 : a), r);
      if (a < 4) dir_e = upd(2'(a), dir_e, r);
      else out_e = upd(2'(a == 8 ? 3 : a - 4), out_e, r);
      `CHK("drive enable", dir_e, pin_oe)
      `CHK("pin level", out_e, pin_out)
      rd(1'b0, 5'(1 + a % 3));
      `CHK("direction strobe read", dir_e, d)
      rd(1'b0, 5'(5 + a % 3));
      `CHK("output strobe read", out_e, d)
    end
    wr(1'b0, 5'h02, 8'h80);
    dir_e = dir_e & 8'h7F;
    wr(1'b0, 5'h17, 8'h08);
    wr(1'b0, 5'h10, 8'h80);
    r = $urandom;
    ext_en  <= 8'h7F;
    ext_val <= r;
    idle(5);
    rd(1'b1, 5'h02);
    `CHK("swapped pin", out_e ^ 8'h01, pin_out)
    `CHK("pull-up", 8'h80, weak_high_bias_enable)
    `CHK("input value", ((dir_e & (out_e ^ 8'h01)) | (~dir_e & r) | 8'h80) ^ 8'h01, d)
    wr(1'b0, 5'h10, 8'h00);
    wr(1'b0, 5'h12, 8'hFF);
    rd(1'b0, 5'h12);
    `CHK("config readback", 8'h8F, d)
    wr(1'b0, 5'h12, 8'h00);
    wr(1'b0, 5'h17, 8'h00);
    ext_en <= 8'hFF;
    wr(1'b0, 5'h02, 8'hFF);
    clk_en <= 1'b0;
    wr(1'b0, 5'h00, 8'hFF);
    `CHK("frozen", 8'h00, pin_oe)
    clk_en <= 1'b1;
    rd(1'b0, 5'h0C);
    `CHK("reserved read", 8'h00, d)
    rd(1'b1, 5'h05);
    `CHK("alias reserved read", 8'h00, d)
    for (int m = 0; m < 8; m++) begin
      wr(1'b0, 5'h11, 8'(m));
      ext_val <= 8'h02;
      idle(5);
      wr(1'b1, 5'h03, 8'hFF);
      idle(5);
      `CHK("flag cleared", 8'h00, pin_event_flags)
      ext_val <= 8'h00;
      idle(5);
      `CHK("flag on fall", {6'h00, m == 1 || m == 3 || m == 5, 1'b0}, pin_event_flags)
      ext_val <= 8'h02;
      idle(5);
      `CHK("flag on rise", {6'h00, m == 1 || m == 2 || m == 3 || m == 5, 1'b0}, pin_event_flags)
    end
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    `CHK("pins after reset", 16'h0000, {pin_out, pin_event_flags})
    print_verdict();
  end
endmodule
bind epp_port epp_checker chk (.core_clk, .rst, .clk_en, .alias_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .pin_in, .pin_out, .pin_oe, .weak_high_bias_enable, .pin_event_flags);
